// ==== verilog/opsg_pkg.sv ====
// package for the operation status group: bit positions, masks, resets
// assumes one 100 MHz clock and a command decoder outside that issues strobes
package opsg_pkg;
	// ----------------------------------------------------------------
	// widths and bit positions
	// ----------------------------------------------------------------
	localparam int OPSG_W             = 16;
	localparam int OPSG_BIT_FAULT     = 13;
	localparam int OPSG_BIT_RELAY     = 11;
	localparam int OPSG_BIT_HOST      = 10;
	localparam int OPSG_BIT_TRIG_WAIT = 5;
	localparam int OPSG_BIT_SCAN      = 4;
	// ----------------------------------------------------------------
	// masks and resets
	// ----------------------------------------------------------------
	localparam logic [15:0] OPSG_USED_MASK = 16'h2c30;
	localparam logic [15:0] OPSG_ENA_RESET = 16'h0000;
	localparam logic [15:0] OPSG_EVT_RESET = 16'h0000;
	// ----------------------------------------------------------------
	// register selects for the read port
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OPSG_SEL_COND,
		OPSG_SEL_EVENT,
		OPSG_SEL_ENABLE,
		OPSG_SEL_NONE
	} opsg_sel_t;
endpackage

// ==== verilog/opsg_top.sv ====
// operation status group: condition, event and enable registers
// assumes status flags and host strobes are synchronous to clk
`timescale 1ns/10ps
module opsg_top (
	input  wire logic                  clk,
	input  wire logic                  rst_b,
	input  wire logic                  fault_flag,
	input  wire logic                  relay_closed_flag,
	input  wire logic                  host_control_flag,
	input  wire logic                  trigger_wait_flag,
	input  wire logic                  scan_active_flag,
	input  wire logic                  clear_status_command,
	input  wire logic                  enable_write,
	input  wire logic [15:0]           enable_wdata,
	input  wire logic                  read_strobe,
	input  wire opsg_pkg::opsg_sel_t   read_sel,
	output logic      [15:0]           read_data,
	output logic                       read_valid,
	output logic                       summary_out
);
	import opsg_pkg::*;

	logic [15:0] cond_now;
	logic [15:0] cond_reg;
	logic [15:0] event_reg;
	logic [15:0] event_next;
	logic [15:0] enable_reg;
	logic [15:0] read_next;

	// ----------------------------------------------------------------
	// condition vector
	// ----------------------------------------------------------------
	// unused positions are tied low so they can never latch
	always_comb begin
		cond_now                     = '0;
		cond_now[OPSG_BIT_FAULT]     = fault_flag;
		cond_now[OPSG_BIT_RELAY]     = relay_closed_flag;
		cond_now[OPSG_BIT_HOST]      = host_control_flag;
		cond_now[OPSG_BIT_TRIG_WAIT] = trigger_wait_flag;
		cond_now[OPSG_BIT_SCAN]      = scan_active_flag;
	end

	// previous condition, for rising edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cond_reg <= '0;
		end else begin
			cond_reg <= cond_now;
		end
	end

	// ----------------------------------------------------------------
	// event register
	// ----------------------------------------------------------------
	// a new edge in the clear cycle survives: set wins over clear
	always_comb begin
		event_next = clear_status_command ? '0 : event_reg;
		event_next = event_next | (cond_now & ~cond_reg);
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			event_reg <= OPSG_EVT_RESET;
		end else begin
			event_reg <= event_next;
		end
	end

	// ----------------------------------------------------------------
	// enable mask
	// ----------------------------------------------------------------
	// unused bits are dropped on write, so readback is zero there
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			enable_reg <= OPSG_ENA_RESET;
		end else if (enable_write) begin
			enable_reg <= enable_wdata & OPSG_USED_MASK;
		end
	end

	// ----------------------------------------------------------------
	// read port and summary
	// ----------------------------------------------------------------
	// condition is sampled live in the strobe cycle
	always_comb begin
		unique case (read_sel)
			OPSG_SEL_COND:   read_next = cond_now;
			OPSG_SEL_EVENT:  read_next = event_reg;
			OPSG_SEL_ENABLE: read_next = enable_reg;
			OPSG_SEL_NONE:   read_next = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			read_data  <= '0;
			read_valid <= 1'b0;
		end else begin
			read_valid <= read_strobe;
			if (read_strobe) begin
				read_data <= read_next;
			end
		end
	end

	// summary follows the enabled event bits with one cycle of delay
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			summary_out <= 1'b0;
		end else begin
			summary_out <= |(event_reg & enable_reg);
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// attempts begun at the releasing edge would sample inputs from inside
	// reset, so the input-driven checks except AST_UNUSED_ZERO, AST_FAULT_SET and AST_EVENT_HOLD wait until the block has run an edge
	logic check_armed_reg;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			check_armed_reg <= 1'b0;
		end else begin
			check_armed_reg <= 1'b1;
		end
	end

	sequence s_rise_fault;
		!fault_flag ##1 fault_flag;
	endsequence

	sequence s_held_fault;
		event_reg[OPSG_BIT_FAULT] [*2];
	endsequence

	AST_COND_READ: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && read_strobe && read_sel == OPSG_SEL_COND
			|=> read_data == $past(cond_now))
		else $error("condition read mismatch");

	AST_EVENT_READ: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && read_strobe && read_sel == OPSG_SEL_EVENT
			|=> read_data == $past(event_reg))
		else $error("event read mismatch");

	AST_UNUSED_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
		((event_reg | cond_now) & ~OPSG_USED_MASK) == '0)
		else $error("unused bit set");

	AST_FAULT_SET: assert property (@(posedge clk) disable iff (!rst_b)
		s_rise_fault ##1 !clear_status_command |-> s_held_fault)
		else $error("fault event not latched");

	AST_SCAN_SET: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && $rose(scan_active_flag) |=> event_reg[OPSG_BIT_SCAN])
		else $error("scan event not latched");

	AST_ENA_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && enable_write
			|=> enable_reg == ($past(enable_wdata) & OPSG_USED_MASK))
		else $error("enable write lost");

	AST_ENA_UNUSED: assert property (@(posedge clk) disable iff (!rst_b)
		(enable_reg & ~OPSG_USED_MASK) == '0)
		else $error("enable unused bit set");

	AST_EVENT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		!clear_status_command && event_reg != '0 |=> (event_reg & $past(event_reg))
			== $past(event_reg))
		else $error("event bit dropped without clear");

	AST_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && clear_status_command
			|=> event_reg == ($past(cond_now) & ~$past(cond_reg)))
		else $error("clear did not empty event");

	AST_SUMMARY: assert property (@(posedge clk) disable iff (!rst_b)
		##1 summary_out == |($past(event_reg) & $past(enable_reg)))
		else $error("summary mismatch");

	AST_READ_VALID: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg |=> read_valid == $past(read_strobe))
		else $error("read valid not one cycle after strobe");

	AST_READ_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && !read_strobe |=> $stable(read_data))
		else $error("read data changed without a read");

	AST_NONE_ZERO: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && read_strobe && read_sel == OPSG_SEL_NONE
			|=> read_data == '0)
		else $error("empty select did not read zero");

	AST_RELAY_SET: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && $rose(relay_closed_flag) |=> event_reg[OPSG_BIT_RELAY])
		else $error("relay event not latched");

	AST_HOST_SET: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && $rose(host_control_flag) |=> event_reg[OPSG_BIT_HOST])
		else $error("host control event not latched");

	AST_TRIG_SET: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && $rose(trigger_wait_flag) |=> event_reg[OPSG_BIT_TRIG_WAIT])
		else $error("trigger wait event not latched");

	AST_EVENT_NEW_EDGE: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg |=> (event_reg & ~$past(event_reg)
			& ~($past(cond_now) & ~$past(cond_reg))) == '0)
		else $error("event bit set without a rising condition");

	AST_ENA_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && !enable_write |=> $stable(enable_reg))
		else $error("enable mask changed without a write");

	AST_ENA_RESET: assert property (@(posedge clk) disable iff (!rst_b)
		!check_armed_reg |-> enable_reg == OPSG_ENA_RESET)
		else $error("enable mask not clear after reset");

	AST_OUT_RESET: assert property (@(posedge clk) disable iff (!rst_b)
		!check_armed_reg |-> event_reg == OPSG_EVT_RESET && !summary_out && !read_valid)
		else $error("state not clear after reset");

	AST_SUMMARY_MASKED: assert property (@(posedge clk) disable iff (!rst_b)
		check_armed_reg && enable_reg == '0 |=> !summary_out)
		else $error("summary raised with empty mask");

	// fault rises while its mask bit is set: summary two edges after the rise
	sequence s_armed_rise_fault;
		check_armed_reg ##0 s_rise_fault;
	endsequence

	sequence s_fault_enabled;
		s_armed_rise_fault ##1 enable_reg[OPSG_BIT_FAULT];
	endsequence

	AST_SUMMARY_FAULT: assert property (@(posedge clk) disable iff (!rst_b)
		s_fault_enabled |=> summary_out)
		else $error("enabled fault did not raise summary");
endmodule

// ==== verification/tb_top.sv ====
// self-checking bench for the operation status group
// assumes opsg_pkg is compiled first; the bench drives every port itself
`timescale 1ns/10ps
module tb_top;
	import opsg_pkg::*;
	// ----------------------------------------------------------------
	// stimulus and reference state
	// ----------------------------------------------------------------
	logic             clk = 1'b0;
	logic             rst_b = 1'b0;
	logic [4:0]       fl = 5'h1f;
	logic             clr = 1'b0;
	logic             ena_wr = 1'b0;
	logic [15:0]      ena_wdata = 16'h0000;
	logic             rd_stb = 1'b0;
	opsg_sel_t        rd_sel = OPSG_SEL_COND;
	logic [15:0]      read_data;
	logic             read_valid;
	logic             summary_out;
	logic [15:0]      ev_m, prev_m, en_m, pexp, last;
	logic             sum_m, pend;
	int               error_cnt = 0;
	int               checked = 0;

	always #5 clk = ~clk;

	opsg_top uut (.clk(clk), .rst_b(rst_b), .fault_flag(fl[4]), .relay_closed_flag(fl[3]),
		.host_control_flag(fl[2]), .trigger_wait_flag(fl[1]), .scan_active_flag(fl[0]),
		.clear_status_command(clr), .enable_write(ena_wr), .enable_wdata(ena_wdata),
		.read_strobe(rd_stb), .read_sel(rd_sel), .read_data(read_data),
		.read_valid(read_valid), .summary_out(summary_out));

	// live condition word, positions written out by hand on purpose
	function automatic logic [15:0] cnd();
		return {2'b00, fl[4], 1'b0, fl[3], fl[2], 4'h0, fl[1], fl[0], 4'h0};
	endfunction

	// expected read answer for the selected register
	function automatic logic [15:0] exp_rd(opsg_sel_t s);
		case (s)
			OPSG_SEL_COND:   return cnd();
			OPSG_SEL_EVENT:  return ev_m;
			OPSG_SEL_ENABLE: return en_m;
			default:         return 16'h0000;
		endcase
	endfunction

	// reference registers; prev resets to 0 so flags high at release set events
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{ev_m, prev_m, en_m, sum_m} <= '0;
		end else begin
			ev_m <= (clr ? 16'h0000 : ev_m) | (cnd() & ~prev_m);
			prev_m <= cnd();
			sum_m <= |(ev_m & en_m);
			if (ena_wr) begin
				en_m <= ena_wdata & 16'h2c30;
			end
		end
	end

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, s, e);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// summary level is compared every cycle away from the edge
	always @(negedge clk) begin
		chk({15'h0, summary_out}, {15'h0, sum_m});
	end

	// ----------------------------------------------------------------
	// main sequence: random traffic with two resets in it
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h1d95));
		{pend, pexp, last} = '0;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 2000; i++) begin
			@(posedge clk);
			// flags mostly stable so events also stay quiet for a while
			if ($urandom % 4 == 0) fl <= 5'($urandom);
			if (i == 1000) rst_b <= 1'b0;
			if (i == 1002) rst_b <= 1'b1;
			clr <= ($urandom % 8) == 0;
			ena_wr <= ($urandom % 4) == 0;
			ena_wdata <= (i < 4) ? 16'hffff : 16'($urandom);
			rd_stb <= (i < 8) || ($urandom % 2);
			rd_sel <= opsg_sel_t'(i < 8 ? i % 4 : $urandom % 4);
			#1;
			if (!rst_b) last = 16'h0000;
			else if (pend) last = pexp;
			chk({15'h0, read_valid}, {15'h0, pend && rst_b});
			chk(read_data, last);
			pend = rd_stb && rst_b;
			pexp = exp_rd(rd_sel);
		end
		results();
	end

	// watchdog: the run needs about 2000 cycles
	initial begin
		#100000;
		error_cnt++;
		results();
	end
endmodule
